// ===== hw/cpms_top.sv
// control pin mode select: shared pin routing, serial programming port, strap decode
`timescale 1ns/10ps
`default_nettype none
module cpms_top #(
	parameter logic [7:0] ENABLE_TABLE = 8'hE4,
	parameter logic [7:0] WIDTH_TABLE  = 8'hC6,
	parameter logic [7:0] SERIAL_TABLE = 8'h24,
	parameter logic [7:0] FORMAT_TABLE = 8'hE4
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_RESET_PIN,
	input  wire logic        I_SHARED_SERIAL_CLOCK_PIN,
	input  wire logic        I_SHARED_SERIAL_DATA_PIN,
	input  wire logic [1:0]  I_SHARED_SERIAL_ENABLE_PIN,
	input  wire logic        I_GLOBAL_POWERDOWN_PIN,
	input  wire logic [1:0]  I_INTERFACE_WIDTH_STRAP,
	input  wire logic [1:0]  I_SERIALIZATION_FACTOR_STRAP,
	input  wire logic [1:0]  I_RESERVED_STRAP,
	input  wire logic [1:0]  I_DATA_FORMAT_STRAP,
	input  wire logic [7:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic      [31:0] O_AVS_READDATA,
	output logic             O_SERIAL_MODE,
	output logic             O_TWO_WIRE,
	output logic             O_DDR_BIT_CLOCK,
	output logic             O_SERIALIZE_16X,
	output logic             O_CAPTURE_FALLING,
	output logic             O_STRAIGHT_BINARY,
	output logic             O_LSB_FIRST,
	output logic             O_COARSE_GAIN,
	output logic             O_EXTERNAL_REF,
	output logic             O_GLOBAL_POWERDOWN,
	output logic             O_DESKEW,
	output logic             O_SYNC,
	output logic             O_RESERVED_STRAP_BAD
);

	localparam int unsigned DW = cpms_pkg::DATA_W;

	logic [DW-1:0]                   cfg_r [0:cpms_pkg::NUM_REGS-1];
	logic                            serial_mode;
	logic                            clk_pin_prev_r;
	logic                            clk_rise;
	logic [cpms_pkg::FRAME_BITS-1:0] shift_r;
	logic [4:0]                      bit_cnt_r;
	logic                            frame_done;
	logic [cpms_pkg::FRAME_BITS-1:0] frame_word;
	logic                            wr_en;
	logic [4:0]                      wr_addr;
	logic [DW-1:0]                   wr_data;
	logic                            sw_reset;
	logic                            av_req;
	logic                            av_ack_r;
	logic [5:0]                      av_idx;
	logic                            av_wr;
	logic [31:0]                     status;
	logic [31:0]                     readdata_nxt;
	logic [1:0]                      enable_set;
	logic [1:0]                      width_set;
	logic [1:0]                      serial_set;
	logic [1:0]                      format_set;
	logic                            two_wire_nxt;
	logic                            ddr_nxt;
	logic                            ser16_nxt;
	logic                            capt_fall_nxt;
	logic                            straight_nxt;
	logic                            lsb_first_nxt;
	logic                            coarse_nxt;
	logic                            ext_ref_nxt;
	logic                            pwrdn_nxt;
	logic                            deskew_nxt;
	logic                            sync_nxt;
	cpms_pkg::cpms_par_mode_t        par_mode;

	// the reset pin level is looked at on every clock; it is the mode switch
	assign serial_mode = !I_RESET_PIN;

	// ---------------- serial programming port ----------------
	// pins arrive synchronous, so one previous sample is enough to find the edge
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			clk_pin_prev_r <= 1'b0;
		end else begin
			clk_pin_prev_r <= I_SHARED_SERIAL_CLOCK_PIN;
		end
	end

	assign clk_rise = serial_mode && I_SHARED_SERIAL_CLOCK_PIN && !clk_pin_prev_r;

	// enable low (level code 0) selects the chip; any higher level deselects
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			shift_r   <= '0;
			bit_cnt_r <= '0;
		end else if (!serial_mode || I_SHARED_SERIAL_ENABLE_PIN != cpms_pkg::LEVEL_GND) begin
			bit_cnt_r <= '0;
		end else if (clk_rise) begin
			shift_r   <= {shift_r[cpms_pkg::FRAME_BITS-2:0], I_SHARED_SERIAL_DATA_PIN};
			bit_cnt_r <= (bit_cnt_r == 5'(cpms_pkg::FRAME_BITS - 1)) ? 5'h00 : bit_cnt_r + 5'h01;
		end
	end

	assign frame_done = serial_mode && clk_rise && (I_SHARED_SERIAL_ENABLE_PIN == cpms_pkg::LEVEL_GND)
		&& (bit_cnt_r == 5'(cpms_pkg::FRAME_BITS - 1));
	assign frame_word = {shift_r[cpms_pkg::FRAME_BITS-2:0], I_SHARED_SERIAL_DATA_PIN};

	// ---------------- avalon slave ----------------
	// one wait cycle per access so that read data come from a flop
	assign av_req            = I_AVS_READ || I_AVS_WRITE;
	assign O_AVS_WAITREQUEST = av_req && !av_ack_r;
	assign av_idx            = I_AVS_ADDRESS[7:2];
	assign av_wr             = I_AVS_WRITE && !av_ack_r && (av_idx <= 6'(cpms_pkg::AV_IDX_REGMAX));

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			av_ack_r <= 1'b0;
		end else begin
			av_ack_r <= av_req && !av_ack_r;
		end
	end

	// serial frames win over a bus write in the same cycle; the bus write is then dropped
	always_comb begin
		wr_en   = 1'b0;
		wr_addr = '0;
		wr_data = '0;
		if (frame_done) begin
			wr_en   = 1'b1;
			wr_addr = frame_word[cpms_pkg::FRAME_BITS-1 -: cpms_pkg::ADDR_W];
			wr_data = frame_word[DW-1:0];
		end else if (av_wr) begin
			wr_en   = 1'b1;
			wr_addr = av_idx[4:0];
			wr_data = I_AVS_WRITEDATA[DW-1:0];
		end
	end

	assign sw_reset = wr_en && (wr_addr == cpms_pkg::REG_SW_RESET) && wr_data[cpms_pkg::BIT_SW_RESET];

	// ---------------- configuration register bank ----------------
	// reset pin high holds the bank at zero, so a high pulse is the hardware reset;
	// serial users must apply it or the software reset before relying on the bank
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < cpms_pkg::NUM_REGS; i++) begin
				cfg_r[i] <= cpms_pkg::REG_RST_VAL;
			end
		end else if (!serial_mode || sw_reset) begin
			for (int i = 0; i < cpms_pkg::NUM_REGS; i++) begin
				cfg_r[i] <= cpms_pkg::REG_RST_VAL;
			end
		end else if (wr_en) begin
			cfg_r[wr_addr] <= wr_data;
		end
	end

	// ---------------- parallel strap decoders ----------------
	cpms_level_decode #(
		.OUT_W (2),
		.TABLE (ENABLE_TABLE)
	) u_enable_dec (
		.i_clk     (I_CLK),
		.i_rst_n   (I_RST_N),
		.i_level   (I_SHARED_SERIAL_ENABLE_PIN),
		.o_setting (enable_set)
	);

	cpms_level_decode #(
		.OUT_W (2),
		.TABLE (WIDTH_TABLE)
	) u_width_dec (
		.i_clk     (I_CLK),
		.i_rst_n   (I_RST_N),
		.i_level   (I_INTERFACE_WIDTH_STRAP),
		.o_setting (width_set)
	);

	cpms_level_decode #(
		.OUT_W (2),
		.TABLE (SERIAL_TABLE)
	) u_serial_dec (
		.i_clk     (I_CLK),
		.i_rst_n   (I_RST_N),
		.i_level   (I_SERIALIZATION_FACTOR_STRAP),
		.o_setting (serial_set)
	);

	cpms_level_decode #(
		.OUT_W (2),
		.TABLE (FORMAT_TABLE)
	) u_format_dec (
		.i_clk     (I_CLK),
		.i_rst_n   (I_RST_N),
		.i_level   (I_DATA_FORMAT_STRAP),
		.o_setting (format_set)
	);

	assign par_mode = cpms_par_mode_from_pins(I_SHARED_SERIAL_CLOCK_PIN, I_SHARED_SERIAL_DATA_PIN);

	function automatic cpms_pkg::cpms_par_mode_t cpms_par_mode_from_pins(input logic c, input logic d);
		cpms_pkg::cpms_par_mode_t m;
		case ({c, d})
			2'h1:    m = cpms_pkg::CPMS_PAR_DESKEW;
			2'h2:    m = cpms_pkg::CPMS_PAR_SYNC;
			2'h3:    m = cpms_pkg::CPMS_PAR_POWERDOWN;
			default: m = cpms_pkg::CPMS_PAR_NORMAL;
		endcase
		return m;
	endfunction : cpms_par_mode_from_pins

	// ---------------- effective settings ----------------
	// strap decoders carry one register stage; serial fields read the bank directly
	always_comb begin
		if (serial_mode) begin
			two_wire_nxt  = cfg_r[cpms_pkg::REG_INTERFACE][cpms_pkg::BIT_TWO_WIRE];
			ddr_nxt       = cfg_r[cpms_pkg::REG_INTERFACE][cpms_pkg::BIT_DDR];
			ser16_nxt     = cfg_r[cpms_pkg::REG_INTERFACE][cpms_pkg::BIT_SER16];
			capt_fall_nxt = cfg_r[cpms_pkg::REG_INTERFACE][cpms_pkg::BIT_CAPT_FALL];
			straight_nxt  = cfg_r[cpms_pkg::REG_FORMAT][cpms_pkg::BIT_STRAIGHT];
			lsb_first_nxt = cfg_r[cpms_pkg::REG_FORMAT][cpms_pkg::BIT_LSB_FIRST];
			coarse_nxt    = cfg_r[cpms_pkg::REG_ANALOG][cpms_pkg::BIT_COARSE_GAIN];
			ext_ref_nxt   = cfg_r[cpms_pkg::REG_ANALOG][cpms_pkg::BIT_EXT_REF];
			pwrdn_nxt     = cfg_r[cpms_pkg::REG_ANALOG][cpms_pkg::BIT_POWERDOWN];
			deskew_nxt    = cfg_r[cpms_pkg::REG_ANALOG][cpms_pkg::BIT_DESKEW];
			sync_nxt      = cfg_r[cpms_pkg::REG_ANALOG][cpms_pkg::BIT_SYNC];
		end else begin
			two_wire_nxt  = width_set[1];
			ddr_nxt       = width_set[0];
			ser16_nxt     = serial_set[1];
			capt_fall_nxt = serial_set[0];
			straight_nxt  = format_set[1];
			lsb_first_nxt = format_set[0];
			coarse_nxt    = enable_set[1];
			ext_ref_nxt   = enable_set[0];
			pwrdn_nxt     = (par_mode == cpms_pkg::CPMS_PAR_POWERDOWN);
			deskew_nxt    = (par_mode == cpms_pkg::CPMS_PAR_DESKEW);
			sync_nxt      = (par_mode == cpms_pkg::CPMS_PAR_SYNC);
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_SERIAL_MODE      <= 1'b0;
			O_TWO_WIRE         <= 1'b0;
			O_DDR_BIT_CLOCK    <= 1'b0;
			O_SERIALIZE_16X    <= 1'b0;
			O_CAPTURE_FALLING  <= 1'b0;
			O_STRAIGHT_BINARY  <= 1'b0;
			O_LSB_FIRST        <= 1'b0;
			O_COARSE_GAIN      <= 1'b0;
			O_EXTERNAL_REF     <= 1'b0;
			O_DESKEW           <= 1'b0;
			O_SYNC             <= 1'b0;
		end else begin
			O_SERIAL_MODE      <= serial_mode;
			O_TWO_WIRE         <= two_wire_nxt;
			O_DDR_BIT_CLOCK    <= ddr_nxt;
			O_SERIALIZE_16X    <= ser16_nxt;
			O_CAPTURE_FALLING  <= capt_fall_nxt;
			O_STRAIGHT_BINARY  <= straight_nxt;
			O_LSB_FIRST        <= lsb_first_nxt;
			O_COARSE_GAIN      <= coarse_nxt;
			O_EXTERNAL_REF     <= ext_ref_nxt;
			O_DESKEW           <= deskew_nxt;
			O_SYNC             <= sync_nxt;
		end
	end

	// the dedicated pin overrides every mode, serial or parallel
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_GLOBAL_POWERDOWN <= 1'b0;
		end else begin
			O_GLOBAL_POWERDOWN <= I_GLOBAL_POWERDOWN_PIN || pwrdn_nxt;
		end
	end

	// only a flag: the block cannot stop a board that ties the reserved pin high
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RESERVED_STRAP_BAD <= 1'b0;
		end else begin
			O_RESERVED_STRAP_BAD <= (I_RESERVED_STRAP != cpms_pkg::LEVEL_GND);
		end
	end

	// ---------------- read path ----------------
	always_comb begin
		status                             = '0;
		status[cpms_pkg::ST_SERIAL_MODE]   = O_SERIAL_MODE;
		status[cpms_pkg::ST_TWO_WIRE]      = O_TWO_WIRE;
		status[cpms_pkg::ST_DDR]           = O_DDR_BIT_CLOCK;
		status[cpms_pkg::ST_SER16]         = O_SERIALIZE_16X;
		status[cpms_pkg::ST_CAPT_FALL]     = O_CAPTURE_FALLING;
		status[cpms_pkg::ST_STRAIGHT]      = O_STRAIGHT_BINARY;
		status[cpms_pkg::ST_LSB_FIRST]     = O_LSB_FIRST;
		status[cpms_pkg::ST_COARSE_GAIN]   = O_COARSE_GAIN;
		status[cpms_pkg::ST_EXT_REF]       = O_EXTERNAL_REF;
		status[cpms_pkg::ST_POWERDOWN]     = O_GLOBAL_POWERDOWN;
		status[cpms_pkg::ST_DESKEW]        = O_DESKEW;
		status[cpms_pkg::ST_SYNC]          = O_SYNC;
		status[cpms_pkg::ST_RSVD_BAD]      = O_RESERVED_STRAP_BAD;
		readdata_nxt                       = '0;
		if (av_idx <= 6'(cpms_pkg::AV_IDX_REGMAX)) begin
			readdata_nxt[DW-1:0] = cfg_r[av_idx[4:0]];
		end else if (av_idx == cpms_pkg::AV_IDX_STATUS) begin
			readdata_nxt = status;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_AVS_READDATA <= 32'h0000_0000;
		end else if (I_AVS_READ && !av_ack_r) begin
			O_AVS_READDATA <= readdata_nxt;
		end
	end

endmodule : cpms_top
`default_nettype wire

// ===== hw/cpms_pkg.sv
// package of constants for the control pin mode select block
package cpms_pkg;

	// serial programming frame: 5 address bits, 11 data bits, msb first
	localparam int unsigned ADDR_W      = 5;
	localparam int unsigned DATA_W      = 11;
	localparam int unsigned FRAME_BITS  = 16;
	localparam int unsigned NUM_REGS    = 32;
	localparam logic [10:0] REG_RST_VAL = 11'h000;

	// serial register indices
	localparam logic [4:0] REG_SW_RESET  = 5'h00;
	localparam logic [4:0] REG_INTERFACE = 5'h01;
	localparam logic [4:0] REG_FORMAT    = 5'h02;
	localparam logic [4:0] REG_ANALOG    = 5'h03;

	// field positions inside the serial registers
	localparam int unsigned BIT_SW_RESET    = 0;
	localparam int unsigned BIT_TWO_WIRE    = 0;
	localparam int unsigned BIT_DDR         = 1;
	localparam int unsigned BIT_SER16       = 2;
	localparam int unsigned BIT_CAPT_FALL   = 3;
	localparam int unsigned BIT_STRAIGHT    = 0;
	localparam int unsigned BIT_LSB_FIRST   = 1;
	localparam int unsigned BIT_COARSE_GAIN = 0;
	localparam int unsigned BIT_EXT_REF     = 1;
	localparam int unsigned BIT_POWERDOWN   = 2;
	localparam int unsigned BIT_DESKEW      = 3;
	localparam int unsigned BIT_SYNC        = 4;

	// pin level codes: ground, low fraction, high fraction, analog supply level
	localparam int unsigned LEVEL_W       = 2;
	localparam logic [1:0]  LEVEL_GND     = 2'h0;

	// avalon byte map
	localparam int unsigned AV_ADDR_W     = 8;
	localparam logic [5:0]  AV_IDX_STATUS = 6'h20;
	localparam int unsigned AV_IDX_REGMAX = 31;

	// status word field positions
	localparam int unsigned ST_SERIAL_MODE = 0;
	localparam int unsigned ST_TWO_WIRE    = 1;
	localparam int unsigned ST_DDR         = 2;
	localparam int unsigned ST_SER16       = 3;
	localparam int unsigned ST_CAPT_FALL   = 4;
	localparam int unsigned ST_STRAIGHT    = 5;
	localparam int unsigned ST_LSB_FIRST   = 6;
	localparam int unsigned ST_COARSE_GAIN = 7;
	localparam int unsigned ST_EXT_REF     = 8;
	localparam int unsigned ST_POWERDOWN   = 9;
	localparam int unsigned ST_DESKEW      = 10;
	localparam int unsigned ST_SYNC        = 11;
	localparam int unsigned ST_RSVD_BAD    = 12;

	// two-pin parallel code from {clock pin, data pin}
	typedef enum logic [1:0] {
		CPMS_PAR_NORMAL    = 2'h0,
		CPMS_PAR_DESKEW    = 2'h1,
		CPMS_PAR_SYNC      = 2'h2,
		CPMS_PAR_POWERDOWN = 2'h3
	} cpms_par_mode_t;

endpackage : cpms_pkg

// ===== hw/cpms_level_decode.sv
// lookup of a multi-level strap pin into setting bits
`timescale 1ns/10ps
`default_nettype none
module cpms_level_decode #(
	parameter int unsigned OUT_W = 2,
	parameter logic [4*OUT_W-1:0] TABLE = '0
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [1:0]       i_level,
	output logic      [OUT_W-1:0] o_setting
);

	logic [OUT_W-1:0] setting_nxt;

	always_comb begin
		setting_nxt = TABLE[i_level*OUT_W +: OUT_W];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_setting <= '0;
		end else begin
			o_setting <= setting_nxt;
		end
	end

endmodule : cpms_level_decode
`default_nettype wire

// ===== verif/cpms_top_monitor.sv
// assertion checker for the control pin mode select block
`timescale 1ns/10ps
`default_nettype none
module cpms_top_monitor #(
	parameter logic [7:0] ENABLE_TABLE = 8'hE4,
	parameter logic [7:0] WIDTH_TABLE  = 8'hC6,
	parameter logic [7:0] SERIAL_TABLE = 8'h24,
	parameter logic [7:0] FORMAT_TABLE = 8'hE4
) (
	input wire logic       I_CLK,
	input wire logic       I_RST_N,
	input wire logic       I_RESET_PIN,
	input wire logic       I_SHARED_SERIAL_CLOCK_PIN,
	input wire logic       I_SHARED_SERIAL_DATA_PIN,
	input wire logic [1:0] I_SHARED_SERIAL_ENABLE_PIN,
	input wire logic       I_GLOBAL_POWERDOWN_PIN,
	input wire logic [1:0] I_INTERFACE_WIDTH_STRAP,
	input wire logic [1:0] I_SERIALIZATION_FACTOR_STRAP,
	input wire logic [1:0] I_DATA_FORMAT_STRAP,
	input wire logic       I_AVS_READ,
	input wire logic       I_AVS_WRITE,
	input wire logic       O_AVS_WAITREQUEST,
	input wire logic       O_SERIAL_MODE,
	input wire logic       O_TWO_WIRE,
	input wire logic       O_DDR_BIT_CLOCK,
	input wire logic       O_SERIALIZE_16X,
	input wire logic       O_CAPTURE_FALLING,
	input wire logic       O_STRAIGHT_BINARY,
	input wire logic       O_LSB_FIRST,
	input wire logic       O_COARSE_GAIN,
	input wire logic       O_EXTERNAL_REF,
	input wire logic       O_GLOBAL_POWERDOWN,
	input wire logic       O_DESKEW,
	input wire logic       O_SYNC
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_mode; $stable(I_RESET_PIN)[*3] |-> O_SERIAL_MODE == !I_RESET_PIN; endproperty
	a_mode: assert property (p_mode) else $error("serial mode flag wrong");
	property p_pwr_pin; I_GLOBAL_POWERDOWN_PIN |=> O_GLOBAL_POWERDOWN; endproperty
	a_pwr_pin: assert property (p_pwr_pin) else $error("powerdown pin ignored");
	property p_deskew; I_RESET_PIN && $past(I_RESET_PIN)
		|=> O_DESKEW == (!$past(I_SHARED_SERIAL_CLOCK_PIN) && $past(I_SHARED_SERIAL_DATA_PIN)); endproperty
	a_deskew: assert property (p_deskew) else $error("deskew decode wrong");
	property p_sync; I_RESET_PIN && $past(I_RESET_PIN)
		|=> O_SYNC == ($past(I_SHARED_SERIAL_CLOCK_PIN) && !$past(I_SHARED_SERIAL_DATA_PIN)); endproperty
	a_sync: assert property (p_sync) else $error("sync decode wrong");
	property p_ppd; I_RESET_PIN && $past(I_RESET_PIN) && I_SHARED_SERIAL_CLOCK_PIN
		&& I_SHARED_SERIAL_DATA_PIN |=> O_GLOBAL_POWERDOWN; endproperty
	a_ppd: assert property (p_ppd) else $error("parallel powerdown missing");
	// four samples: the decoder flop is still in reset at the release edge
	property p_gain; (I_RESET_PIN && $stable(I_SHARED_SERIAL_ENABLE_PIN))[*4]
		|-> {O_COARSE_GAIN, O_EXTERNAL_REF} == ENABLE_TABLE[2*I_SHARED_SERIAL_ENABLE_PIN +: 2]; endproperty
	a_gain: assert property (p_gain) else $error("gain or reference decode wrong");
	property p_width; (I_RESET_PIN && $stable(I_INTERFACE_WIDTH_STRAP))[*4]
		|-> {O_TWO_WIRE, O_DDR_BIT_CLOCK} == WIDTH_TABLE[2*I_INTERFACE_WIDTH_STRAP +: 2]; endproperty
	a_width: assert property (p_width) else $error("width decode wrong");
	property p_ser; (I_RESET_PIN && $stable(I_SERIALIZATION_FACTOR_STRAP))[*4]
		|-> {O_SERIALIZE_16X, O_CAPTURE_FALLING} == SERIAL_TABLE[2*I_SERIALIZATION_FACTOR_STRAP +: 2]; endproperty
	a_ser: assert property (p_ser) else $error("serialization decode wrong");
	property p_fmt; (I_RESET_PIN && $stable(I_DATA_FORMAT_STRAP))[*4]
		|-> {O_STRAIGHT_BINARY, O_LSB_FIRST} == FORMAT_TABLE[2*I_DATA_FORMAT_STRAP +: 2]; endproperty
	a_fmt: assert property (p_fmt) else $error("format decode wrong");
	property p_wait; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
endmodule : cpms_top_monitor
`default_nettype wire

// ===== verif/cpms_serial_host.sv
// serial configuration controller model driving the shared pins
`timescale 1ns/10ps
`default_nettype none
module cpms_serial_host (
	input  wire logic       i_clk,
	output logic            o_clk,
	output logic            o_dat,
	output logic      [1:0] o_en
);
	initial begin
		o_clk = 1'b0;
		o_dat = 1'b0;
		o_en  = 2'h3; // pull-up leaves the port deselected
	end
	// first nbits of w, msb first; fewer than 16 aborts the frame; hold sets pace
	task automatic send(input logic [15:0] w, input int nbits, input int hold);
		@(posedge i_clk);
		o_en <= 2'h0; // selected for the whole frame
		for (int i = 0; i < nbits; i++) begin
			o_dat <= w[15-i];
			o_clk <= 1'b0;
			repeat (hold) @(posedge i_clk);
			o_clk <= 1'b1;
			repeat (hold) @(posedge i_clk);
		end
		o_clk <= 1'b0;
		o_dat <= 1'b0; // released line falls to its pull-down
		o_en  <= 2'h3;
		repeat (2) @(posedge i_clk);
	endtask : send
endmodule : cpms_serial_host
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking testbench for the control pin mode select block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
	localparam logic [7:0] EN_TBL = 8'hE4;
	localparam logic [7:0] WD_TBL = 8'hC6;
	localparam logic [7:0] SR_TBL = 8'h24;
	localparam logic [7:0] FM_TBL = 8'hE4;
	logic        clk, rst_n, rst_pin, p_clk, p_dat, pwr_pin, rd, wr, wreq, h_clk, h_dat;
	logic [1:0]  en_lvl, wid_s, ser_s, rsv_s, fmt_s, h_en;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, q;
	wire  [12:0] outs;
	int          err_total, cmp_count, cyc;

	cpms_top #(.ENABLE_TABLE(EN_TBL), .WIDTH_TABLE(WD_TBL), .SERIAL_TABLE(SR_TBL), .FORMAT_TABLE(FM_TBL)) cpms_top_i (
		.I_CLK(clk), .I_RST_N(rst_n), .I_RESET_PIN(rst_pin),
		.I_SHARED_SERIAL_CLOCK_PIN(rst_pin ? p_clk : h_clk), .I_SHARED_SERIAL_DATA_PIN(rst_pin ? p_dat : h_dat),
		.I_SHARED_SERIAL_ENABLE_PIN(rst_pin ? en_lvl : h_en), .I_GLOBAL_POWERDOWN_PIN(pwr_pin),
		.I_INTERFACE_WIDTH_STRAP(wid_s), .I_SERIALIZATION_FACTOR_STRAP(ser_s), .I_RESERVED_STRAP(rsv_s),
		.I_DATA_FORMAT_STRAP(fmt_s), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
		.I_AVS_WRITEDATA(wdata), .O_AVS_WAITREQUEST(wreq), .O_AVS_READDATA(rdata),
		.O_SERIAL_MODE(outs[0]), .O_TWO_WIRE(outs[1]), .O_DDR_BIT_CLOCK(outs[2]), .O_SERIALIZE_16X(outs[3]),
		.O_CAPTURE_FALLING(outs[4]), .O_STRAIGHT_BINARY(outs[5]), .O_LSB_FIRST(outs[6]), .O_COARSE_GAIN(outs[7]),
		.O_EXTERNAL_REF(outs[8]), .O_GLOBAL_POWERDOWN(outs[9]), .O_DESKEW(outs[10]), .O_SYNC(outs[11]),
		.O_RESERVED_STRAP_BAD(outs[12]));
	cpms_serial_host cpms_serial_host_i (.i_clk(clk), .o_clk(h_clk), .o_dat(h_dat), .o_en(h_en));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// holds the request until waitrequest is seen low at a rising edge
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : av

	task automatic t_straps;
		for (int l = 0; l < 4; l++) begin
			@(posedge clk);
			{wid_s, ser_s, fmt_s, en_lvl, rsv_s} <= {5{2'(l)}};
			settle(4);
			`CHK({outs[1], outs[2]}, WD_TBL[2*l +: 2])
			`CHK({outs[3], outs[4]}, SR_TBL[2*l +: 2])
			`CHK({outs[5], outs[6]}, FM_TBL[2*l +: 2])
			`CHK({outs[7], outs[8]}, EN_TBL[2*l +: 2])
			`CHK(outs[12], 1'(l != 0))
		end
		`CHK({outs[1], outs[2]}, 2'h3)
		`CHK({outs[3], outs[4]}, 2'h0)
		@(posedge clk);
		rsv_s <= 2'h0; // board holds the reserved strap at ground
	endtask : t_straps

	task automatic t_par;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			{p_clk, p_dat} <= 2'(c);
			settle(2);
			`CHK(outs[11:9], {c == 2, c == 1, c == 3})
		end
		@(posedge clk);
		{p_clk, p_dat} <= 2'h0;
	endtask : t_par

	task automatic t_pwr;
		@(posedge clk);
		rst_pin <= 1'b0;
		pwr_pin <= 1'b1;
		settle(3);
		`CHK(outs[9], 1'b1)
		`CHK(outs[0], 1'b1)
		@(posedge clk);
		pwr_pin <= 1'b0;
		settle(2);
		`CHK(outs[9], 1'b0)
	endtask : t_pwr

	task automatic t_serial;
		@(posedge clk);
		rst_pin <= 1'b1; // high-going pulse initialises the bank
		settle(3);
		@(posedge clk);
		rst_pin <= 1'b0;
		cpms_serial_host_i.send(16'h080F, 16, 1);
		settle(2);
		`CHK(outs[4:1], 4'hF)
		av(1'b0, 8'h04, 32'h0);
		`CHK(q, 32'h0000000F)
		cpms_serial_host_i.send(16'h1003, 10, 2);
		cpms_serial_host_i.send(16'h1001, 16, 3);
		settle(2);
		`CHK(outs[6:5], 2'h1)
		cpms_serial_host_i.send(16'h0001, 16, 1); // software reset
		settle(2);
		`CHK(outs[6:1], 6'h00)
	endtask : t_serial

	task automatic t_avalon;
		av(1'b1, 8'h08, 32'h00000003);
		settle(2);
		`CHK(outs[6:5], 2'h3)
		av(1'b0, 8'h08, 32'h0);
		`CHK(q, 32'h00000003)
		av(1'b0, 8'h80, 32'h0);
		`CHK(q, 32'h00000061)
		av(1'b0, 8'h84, 32'h0);
		`CHK(q, 32'h0)
		av(1'b1, 8'h0C, 32'h0000001F);
		settle(2);
		`CHK(outs[11:7], 5'h1F)
		@(posedge clk);
		rst_pin <= 1'b1;
		settle(2);
		av(1'b1, 8'h08, 32'h00000003);
		av(1'b0, 8'h08, 32'h0);
		`CHK(q, 32'h0)
	endtask : t_avalon

	initial begin
		{rst_n, rst_pin, p_clk, p_dat, pwr_pin, rd, wr} = 7'h20;
		{en_lvl, wid_s, ser_s, rsv_s, fmt_s} = 10'h000;
		addr = 8'h00;
		wdata = 32'h0;
		err_total = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_straps();
		t_par();
		t_pwr();
		t_serial();
		t_avalon();
		tally_and_finish();
	end
endmodule : tb_top
`undef CHK

bind cpms_top cpms_top_monitor #(.ENABLE_TABLE(ENABLE_TABLE), .WIDTH_TABLE(WIDTH_TABLE),
	.SERIAL_TABLE(SERIAL_TABLE), .FORMAT_TABLE(FORMAT_TABLE)) cpms_top_monitor_i (
	.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_RESET_PIN(I_RESET_PIN),
	.I_SHARED_SERIAL_CLOCK_PIN(I_SHARED_SERIAL_CLOCK_PIN), .I_SHARED_SERIAL_DATA_PIN(I_SHARED_SERIAL_DATA_PIN),
	.I_SHARED_SERIAL_ENABLE_PIN(I_SHARED_SERIAL_ENABLE_PIN), .I_GLOBAL_POWERDOWN_PIN(I_GLOBAL_POWERDOWN_PIN),
	.I_INTERFACE_WIDTH_STRAP(I_INTERFACE_WIDTH_STRAP), .I_SERIALIZATION_FACTOR_STRAP(I_SERIALIZATION_FACTOR_STRAP),
	.I_DATA_FORMAT_STRAP(I_DATA_FORMAT_STRAP), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_SERIAL_MODE(O_SERIAL_MODE), .O_TWO_WIRE(O_TWO_WIRE),
	.O_DDR_BIT_CLOCK(O_DDR_BIT_CLOCK), .O_SERIALIZE_16X(O_SERIALIZE_16X), .O_CAPTURE_FALLING(O_CAPTURE_FALLING),
	.O_STRAIGHT_BINARY(O_STRAIGHT_BINARY), .O_LSB_FIRST(O_LSB_FIRST), .O_COARSE_GAIN(O_COARSE_GAIN),
	.O_EXTERNAL_REF(O_EXTERNAL_REF), .O_GLOBAL_POWERDOWN(O_GLOBAL_POWERDOWN), .O_DESKEW(O_DESKEW), .O_SYNC(O_SYNC));
`default_nettype wire
